// ### serial_line_model.sv
`timescale 1ns/1ns
module serial_line_model (
    input wire logic clock,
    output logic rxd
);
    // idle line rests high, as a stop level
    initial rxd = 1'b1;
    task automatic hold(input logic v, input int c);
        @(posedge clock);
        rxd <= v;
        repeat (c - 1) @(posedge clock);
    endtask
    // a low too short to count as a start
    task automatic low(input int c);
        hold(1'b0, c);
        hold(1'b1, 1);
    endtask
    // one frame, lowest bit first, one stop bit
    task automatic send(input logic [8:0] v, input int n, input int per);
        hold(1'b0, per);
        for (int i = 0; i < n; i++) hold(v[i], per);
        hold(1'b1, per);
    endtask
endmodule

// ### usart_baud_and_receiver.sv
`timescale 1ns/1ns
// Notes on behaviour
// - source is serial clock pin, master clock, or master clock over eight.
// - upper select bit set makes the serial clock pin an input.
// - internal source with clock output enable drives baud clock on pin.
// - internal source without clock output enable frees the serial clock pin for general use.
// - one baud clock feeds receiver and transmitter alike.
// - async bit rate is source over sixteen times divisor.
// - divisor zero stops the baud clock, except with sync external source.
// - sync internal rate is source over divisor, no sixteen.
// - sync external takes pin clock directly, divisor ignored.
// - mode bit 7 low is asynchronous, high synchronous.
// - async start needs low longer than 7 sampling cycles.
// - first async sample 24 sampling cycles after start edge.
// - later async samples every 16 sampling cycles.
// - sync receiver samples on rising baud edge; low while idle starts.
// - sync receiver takes data, parity, stop, then hunts again.
// - five to nine data bits by configuration.
// - finished character loads holding register, sets ready, or overrun.
module usart_baud_and_receiver (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic sck_pin_free,
    input wire logic rxd_i,
    output logic baud_clk_tx
);
    typedef struct packed {
        logic [31:0] mode;
        logic [15:0] div;
        logic [8:0] hold;
        logic ready;
        logic overrun;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] rxd_s;
        logic [1:0] sck_s;
        usart_rx_pkg::rx_state_t st;
        logic [4:0] sub;
        logic [3:0] nbits;
        logic [10:0] shreg;
        logic bclk_prev;
    } state_t;
    state_t s_q, s_d;
    logic tick;
    logic baud_clk;
    logic sync_mode;
    logic ext_src;
    logic par_en;
    logic [3:0] data_bits;
    logic [3:0] frame_bits;
    logic sample_now;
    logic rx_bit;
    logic rx_done;
    logic [8:0] rx_data;
    logic req;
    logic rd_hold;

    // character length: 5..8 from field, 9 when the nine-bit flag set
    function automatic logic [3:0] char_len(input logic [31:0] m);
        if (m[usart_rx_pkg::MODE_NINE_BIT]) begin
            char_len = 4'h9;
        end else begin
            char_len = 4'h5 + {2'h0, m[usart_rx_pkg::MODE_LEN_LSB +: 2]};
        end
    endfunction

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    assign sync_mode = s_q.mode[usart_rx_pkg::MODE_SYNC_BIT];
    assign ext_src = s_q.mode[usart_rx_pkg::MODE_CLKS_LSB + 1];
    assign par_en = s_q.mode[usart_rx_pkg::MODE_PAR_BIT];
    assign data_bits = char_len(s_q.mode);
    // data + parity + stop
    assign frame_bits = data_bits + {3'h0, par_en} + 4'h1;
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign rd_hold = req & ~wb_we_i & (wb_adr_i == usart_rx_pkg::OFS_RX_HOLD);

    usart_baud_gen u_baud (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clock_source_select(s_q.mode[usart_rx_pkg::MODE_CLKS_LSB +: 2]),
        .clock_divisor(s_q.div),
        .sync_mode(sync_mode),
        .sck_sync(s_q.sck_s[1]),
        .baud_clk(baud_clk),
        .tick(tick)
    );

    // receive path: shared baud clock also leaves for the transmitter
    always_comb begin
        s_d = s_q;
        sample_now = 1'b0;
        rx_done = 1'b0;
        rx_bit = s_q.rxd_s[1];
        rx_data = 9'h000;
        s_d.rxd_s = {s_q.rxd_s[0], rxd_i};
        s_d.sck_s = {s_q.sck_s[0], sck_i};
        s_d.bclk_prev = baud_clk;
        s_d.ack = req;
        if (tick) begin
            case (s_q.st)
                usart_rx_pkg::RX_HUNT: begin
                    if (!rx_bit) begin
                        s_d.nbits = 4'h0;
                        if (sync_mode) begin
                            s_d.st = usart_rx_pkg::RX_BITS;
                        end else begin
                            s_d.sub = 5'h01;
                            s_d.st = usart_rx_pkg::RX_START;
                        end
                    end
                end
                usart_rx_pkg::RX_START: begin
                    if (rx_bit) begin
                        s_d.st = usart_rx_pkg::RX_HUNT;
                    end else if (s_q.sub == usart_rx_pkg::START_MIN_LOW) begin
                        s_d.sub = s_q.sub + 5'h01;
                        s_d.st = usart_rx_pkg::RX_BITS;
                    end else begin
                        s_d.sub = s_q.sub + 5'h01;
                    end
                end
                usart_rx_pkg::RX_BITS: begin
                    if (sync_mode) begin
                        sample_now = 1'b1;
                    end else if (s_q.sub == usart_rx_pkg::FIRST_SAMPLE) begin
                        sample_now = 1'b1;
                        s_d.sub = usart_rx_pkg::FIRST_SAMPLE - usart_rx_pkg::BIT_SPACING + 5'h01;
                    end else begin
                        s_d.sub = s_q.sub + 5'h01;
                    end
                    if (sample_now) begin
                        s_d.shreg = {rx_bit, s_q.shreg[10:1]};
                        s_d.nbits = s_q.nbits + 4'h1;
                        if (s_q.nbits + 4'h1 == frame_bits) begin
                            rx_done = 1'b1;
                            s_d.st = usart_rx_pkg::RX_HUNT;
                        end
                    end
                end
                default: s_d.st = usart_rx_pkg::RX_HUNT;
            endcase
        end
        // align collected frame: shreg holds frame_bits at the top
        rx_data = 9'(({rx_bit, s_q.shreg[10:1]} >> (5'd11 - {1'b0, frame_bits}))
                  & ((11'h001 << data_bits) - 11'h001));
        // bus registers
        if (req && wb_we_i) begin
            case (wb_adr_i)
                usart_rx_pkg::OFS_MODE: s_d.mode = merge(s_q.mode, wb_dat_i, wb_sel_i);
                usart_rx_pkg::OFS_BAUD_DIV: s_d.div = 16'(merge({16'h0000, s_q.div},
                                                             wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
        // read data is taken only with a request, so it holds while idle
        if (req) begin
            case (wb_adr_i)
                usart_rx_pkg::OFS_MODE: s_d.rdata = s_q.mode;
                usart_rx_pkg::OFS_BAUD_DIV: s_d.rdata = {16'h0000, s_q.div};
                usart_rx_pkg::OFS_STATUS: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rdata[usart_rx_pkg::STAT_READY_BIT] = s_q.ready;
                    s_d.rdata[usart_rx_pkg::STAT_OVERRUN_BIT] = s_q.overrun;
                end
                usart_rx_pkg::OFS_RX_HOLD: s_d.rdata = {23'h000000, s_q.hold};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // reading status clears overrun; holding read clears ready; new char wins
        if (req && !wb_we_i && wb_adr_i == usart_rx_pkg::OFS_STATUS) begin
            s_d.overrun = 1'b0;
        end
        if (rd_hold) begin
            s_d.ready = 1'b0;
        end
        if (rx_done) begin
            s_d.hold = rx_data;
            s_d.ready = 1'b1;
            if (s_q.ready && !rd_hold) begin
                s_d.overrun = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.mode <= usart_rx_pkg::MODE_RESET;
            s_q.div <= usart_rx_pkg::BAUD_DIV_RESET;
            s_q.rxd_s <= 2'h3;
            s_q.st <= usart_rx_pkg::RX_HUNT;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    // pin direction follows the source select and clock output enable
    assign sck_oe = ~ext_src & s_q.mode[usart_rx_pkg::MODE_CLK_OUT_BIT];
    assign sck_o = baud_clk;
    assign sck_pin_free = ~ext_src & ~s_q.mode[usart_rx_pkg::MODE_CLK_OUT_BIT];
    assign baud_clk_tx = baud_clk;
endmodule

// ### usart_baud_and_receiver_sva.sv
`timescale 1ns/1ns
module usart_baud_and_receiver_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic sck_pin_free,
    input wire logic baud_clk_tx
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // bus handshake: answer one cycle later, one cycle long
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // read data only moves when a request was taken
    a_rdata_holds: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    // pin ownership
    a_pin_exclusive: assert property (sck_oe |-> !sck_pin_free)
        else $error("pin driven and freed at once");
    a_pin_mirrors_baud: assert property (sck_oe |-> sck_o == baud_clk_tx)
        else $error("pin clock differs from baud clock");
    a_reset_pins: assert property ($rose(rst_n) |-> !sck_oe && sck_pin_free && !wb_ack_o)
        else $error("pin state wrong after reset");
    // frozen clock enable stops the generator
    a_freeze_hold: assert property (!clk_en |=> $stable(baud_clk_tx) && $stable(sck_oe))
        else $error("state moved while frozen");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_drive: cover property ($rose(sck_oe));
endmodule

// ### usart_baud_and_receiver_tb.sv
`timescale 1ns/1ns
module usart_baud_and_receiver_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sck_i = 1'b0, sck_run = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, got;
    logic ack, sck_o, sck_oe, pin_free, rxd, baud;
    int failures = 0;
    int compares = 0;
    always #20 clock = ~clock;
    usart_baud_and_receiver dut_u (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
        .sck_pin_free(pin_free), .rxd_i(rxd), .baud_clk_tx(baud)
    );
    serial_line_model line_u (.clock(clock), .rxd(rxd));
    // external clock at a tenth of the master rate, still when unused
    always begin
        repeat (5) @(posedge clock);
        sck_i <= sck_run & ~sck_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(got, exp);
    endtask
    task automatic t_reset;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        wb(1'b1, 8'hF0, 32'hFFFF_FFFF);
        rd(8'hF0, 32'h0);
    endtask
    // pin direction follows source and clock output enable
    task automatic t_pin;
        wb(1'b1, 8'h00, 32'h0004_0000);
        repeat (3) @(posedge clock);
        chk({31'h0, sck_oe}, 32'h1);
        wb(1'b1, 8'h00, 32'h0004_0020);
        repeat (3) @(posedge clock);
        chk({31'h0, sck_oe}, 32'h0);
        wb(1'b1, 8'h00, 32'h0);
        repeat (3) @(posedge clock);
        chk({31'h0, pin_free}, 32'h1);
    endtask
    // rising baud edges in an 80 cycle window per mode
    task automatic t_rates;
        logic [31:0] modes [5] = '{32'h80, 32'h80, 32'h90, 32'h00, 32'hA0};
        logic [31:0] divs [5] = '{32'h0, 32'h4, 32'h1, 32'h1, 32'h0};
        int exps [5] = '{0, 20, 10, 5, 8};
        int n;
        logic p;
        for (int i = 0; i < 5; i++) begin
            sck_run <= (i == 4);
            wb(1'b1, 8'h00, modes[i]);
            wb(1'b1, 8'h04, divs[i]);
            repeat (60) @(posedge clock);
            n = 0;
            p = baud;
            repeat (80) begin
                @(posedge clock);
                if (baud && !p) n++;
                p = baud;
            end
            chk(n, exps[i]);
        end
        clk_en <= 1'b0;
        repeat (20) @(posedge clock);
        clk_en <= 1'b1;
        sck_run <= 1'b0;
    endtask
    // five-bit frames at 32 cycles a bit, 16x tick every 2 cycles
    task automatic t_async;
        wb(1'b1, 8'h04, 32'h2);
        wb(1'b1, 8'h00, 32'h0);
        line_u.low(10);
        repeat (100) @(posedge clock);
        rd(8'h08, 32'h0);
        line_u.send(9'h15, 5, 32);
        repeat (60) @(posedge clock);
        rd(8'h08, 32'h1);
        rd(8'h0C, 32'h15);
        rd(8'h08, 32'h0);
        line_u.send(9'h0A, 5, 32);
        line_u.send(9'h13, 5, 32);
        repeat (60) @(posedge clock);
        rd(8'h08, 32'h21);
        rd(8'h0C, 32'h13);
    endtask
    // sync frames at 4 cycles a bit: 8 bits with parity, then nine bits
    task automatic t_sync;
        wb(1'b1, 8'h04, 32'h4);
        wb(1'b1, 8'h00, 32'h18C);
        line_u.send(9'h1A5, 9, 4);
        repeat (20) @(posedge clock);
        rd(8'h0C, 32'hA5);
        wb(1'b1, 8'h00, 32'h2_0080);
        line_u.send(9'h1C3, 9, 4);
        repeat (20) @(posedge clock);
        rd(8'h08, 32'h1);
        rd(8'h0C, 32'h1C3);
    endtask
    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_pin();
        t_rates();
        t_async();
        t_sync();
        complete_run();
    end
    // hang guard, well past the expected run
    initial begin
        #800000;
        failures++;
        complete_run();
    end
endmodule
bind usart_baud_and_receiver usart_baud_and_receiver_chk chk_u (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sck_o(sck_o), .sck_oe(sck_oe), .sck_pin_free(sck_pin_free), .baud_clk_tx(baud_clk_tx)
);

// ### usart_baud_gen.sv
`timescale 1ns/1ns
module usart_baud_gen (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [1:0] clock_source_select,
    input wire logic [15:0] clock_divisor,
    input wire logic sync_mode,
    input wire logic sck_sync,
    output logic baud_clk,
    output logic tick
);
    typedef struct packed {
        logic [2:0] pre;
        logic [15:0] cnt;
        logic [3:0] ph;
        logic bclk;
        logic sck_prev;
        logic tick;
    } state_t;
    state_t s_q, s_d;
    logic src_en;
    logic ext;

    // one master-clock-wide enable from the selected source
    always_comb begin
        s_d = s_q;
        ext = clock_source_select[1];
        s_d.pre = s_q.pre + 3'h1;
        s_d.sck_prev = sck_sync;
        s_d.tick = 1'b0;
        case (clock_source_select)
            2'h0: src_en = 1'b1;
            2'h1: src_en = (s_q.pre == usart_rx_pkg::MASTER_PRESCALE);
            default: src_en = sck_sync & ~s_q.sck_prev;
        endcase
        if (ext && sync_mode) begin
            // pin drives the bit clock directly, divisor unused
            s_d.bclk = sck_sync;
            s_d.tick = sck_sync & ~s_q.sck_prev;
            s_d.cnt = 16'h0000;
        end else if (clock_divisor == 16'h0000) begin
            s_d.cnt = 16'h0000;
            s_d.bclk = 1'b0;
        end else if (src_en) begin
            // async: tick is the 16x sampling clock, bclk toggles per 8 ticks
            if (s_q.cnt + 16'h0001 >= clock_divisor) begin
                s_d.cnt = 16'h0000;
                s_d.tick = 1'b1;
                s_d.ph = s_q.ph + 4'h1;
                s_d.bclk = sync_mode ? 1'b1 : s_d.ph[3];
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end
        // sync internal: drop halfway, also between slow source pulses
        // limitation: divisor 1 on the master clock leaves the level high
        if (sync_mode && !ext && !s_d.tick && (s_d.cnt >= (clock_divisor >> 1))) begin
            s_d.bclk = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
    assign baud_clk = s_q.bclk;
endmodule

// ### usart_rx_pkg.sv
package usart_rx_pkg;
    // mode register layout
    localparam int MODE_SYNC_BIT = 7;
    localparam int MODE_CLKS_LSB = 4;
    // length field sits below the clock select, clear of the sync bit
    localparam int MODE_LEN_LSB = 2;
    localparam int MODE_PAR_BIT = 8;
    localparam int MODE_CLK_OUT_BIT = 18;
    localparam int MODE_NINE_BIT = 17;
    // register offsets, byte addresses
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_BAUD_DIV = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RX_HOLD = 8'h0C;
    // reset values
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
    // status bit positions
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 5;
    // receiver timing in sampling-clock cycles, then the master clock prescale count
    localparam logic [4:0] START_MIN_LOW = 5'h07;
    localparam logic [4:0] FIRST_SAMPLE = 5'h18;
    localparam logic [4:0] BIT_SPACING = 5'h10;
    localparam logic [2:0] MASTER_PRESCALE = 3'h7;
    // clock source select codes
    typedef enum logic [1:0] {
        SRC_MASTER = 2'h0,
        SRC_MASTER_DIV8 = 2'h1,
        SRC_EXT_A = 2'h2,
        SRC_EXT_B = 2'h3
    } clk_src_t;
    typedef enum logic [1:0] {
        RX_HUNT = 2'h0,
        RX_START = 2'h1,
        RX_BITS = 2'h3
    } rx_state_t;
endpackage
